// ### rtl/loop_guard_pkg.sv
package loop_guard_pkg;

    // =====================================================================
    // register map, byte addresses
    // =====================================================================
    localparam logic [31:0] MODE_ADDR    = 32'h0000FF48;
    localparam logic [31:0] RESTART_ADDR = 32'h0000FF4C;
    localparam logic [31:0] CAUSE_ADDR   = 32'h0000FF50;

    // =====================================================================
    // reset values and fixed patterns
    // =====================================================================
    localparam logic [7:0] MODE_RESET    = 8'h67;
    localparam logic [7:0] RESTART_READ  = 8'h9A;
    localparam logic [7:0] RESTART_KEY   = 8'hAC;
    localparam logic [2:0] MODE_FIXED    = 3'h3;
    localparam logic [7:0] CAUSE_RESET   = 8'h00;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int MODE_CLK_HI_POS  = 4;
    localparam int MODE_CLK_LO_POS  = 3;
    localparam int MODE_OVF_MSB     = 2;
    localparam int MODE_FIXED_LSB   = 5;
    localparam int CAUSE_FLAG_POS   = 4;

    // =====================================================================
    // counter sizing
    // =====================================================================
    localparam int          CNT_W     = 21;
    localparam logic [4:0]  SLOW_BASE = 5'h0B;
    localparam logic [4:0]  SYS_BASE  = 5'h0D;

    // =====================================================================
    // bus codes and enumerations
    // =====================================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    typedef enum logic [1:0] {
        SRC_SLOW = 2'b00,
        SRC_SYS  = 2'b01,
        SRC_STOP = 2'b10
    } src_t;

    typedef enum logic [1:0] {
        SEL_NONE    = 2'b00,
        SEL_MODE    = 2'b01,
        SEL_RESTART = 2'b10,
        SEL_CAUSE   = 2'b11
    } sel_t;

endpackage

// ### rtl/loop_guard_counter.sv
`timescale 1ns/1ps
module loop_guard_counter (
    input  wire logic                          clk,       // system clock
    input  wire logic                          rst_n,     // async reset
    input  wire logic                          clear,     // zero the count
    input  wire logic                          tick,      // one count step
    input  wire logic                          src_sys,   // system clock base
    input  wire logic [2:0]                    ovf_sel,   // period code
    output logic                               overflow,  // limit reached
    output logic [loop_guard_pkg::CNT_W-1:0]   count      // current count
);

    logic [4:0]                        pow;
    logic [loop_guard_pkg::CNT_W-1:0]  last;

    // =====================================================================
    // period selection
    // =====================================================================
    assign pow = (src_sys ? loop_guard_pkg::SYS_BASE
                          : loop_guard_pkg::SLOW_BASE) + {2'b00, ovf_sel};

    genvar i;
    generate
        for (i = 0; i < loop_guard_pkg::CNT_W; i = i + 1) begin : g_last
            assign last[i] = (5'(i) < pow);
        end
    endgenerate

    // overflow on the step that would reach 2^pow
    assign overflow = tick && (count == last);

    // =====================================================================
    // binary up counter
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clear || overflow) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

endmodule

// ### rtl/loop_guard.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module loop_guard (
    input  wire logic        clk,                 // 40 MHz system clock
    input  wire logic        rst_n,               // power-on reset, async
    input  wire logic        hsel,                // slave select
    input  wire logic [31:0] haddr,               // byte address
    input  wire logic [1:0]  htrans,              // transfer type
    input  wire logic        hwrite,              // write not read
    input  wire logic [2:0]  hsize,               // transfer size
    input  wire logic [31:0] hwdata,              // write data
    input  wire logic        hready,              // bus ready in
    output logic             hreadyout,           // slave ready
    output logic [31:0]      hrdata,              // read data
    output logic             hresp,               // always okay
    input  wire logic        bit_manip,           // 1-bit access marker
    input  wire logic        option_unstoppable,  // strap: slow osc fixed
    input  wire logic        slow_tick,           // slow clock step
    input  wire logic        sys_tick,            // system clock step
    input  wire logic        sys_clk_running,     // fx oscillating
    input  wire logic        halt_mode,           // cpu in halt
    input  wire logic        stop_mode,           // cpu in stop
    input  wire logic        osc_stabilizing,     // fx settling
    input  wire logic        slow_osc_stopped,    // slow osc off by sw
    input  wire logic        cpu_on_sys_clk,      // cpu runs on fx
    output logic             internal_reset,      // one-cycle reset pulse
    output logic             loop_guard_reset_cause_flag, // cause bit
    output logic             counting             // counter advancing
);

    // =====================================================================
    // state
    // =====================================================================
    logic [7:0]                       mode_r;
    logic                             mode_written_r;
    logic                             stopped_r;
    logic                             opt_r;
    logic                             opt_taken_r;
    logic                             cause_r;
    logic                             int_rst_r;
    logic                             counting_r;
    logic                             hready_r;
    logic [31:0]                      hrdata_r;
    logic                             hresp_r;
    logic                             wr_pend_r;
    loop_guard_pkg::sel_t             wr_sel_r;
    logic                             wr_bit_r;

    // =====================================================================
    // decode
    // =====================================================================
    logic                             addr_phase;
    logic                             hit_mode;
    logic                             hit_restart;
    logic                             hit_cause;
    loop_guard_pkg::sel_t             sel_now;
    logic [7:0]                       rd_byte;
    logic                             rd_cause;
    logic [7:0]                       wdata;

    assign addr_phase  = hsel && hready &&
                         (htrans == loop_guard_pkg::HTRANS_NONSEQ ||
                          htrans == loop_guard_pkg::HTRANS_SEQ);
    assign hit_mode    = (haddr == loop_guard_pkg::MODE_ADDR);
    assign hit_restart = (haddr == loop_guard_pkg::RESTART_ADDR);
    assign hit_cause   = (haddr == loop_guard_pkg::CAUSE_ADDR);
    assign sel_now     = hit_mode    ? loop_guard_pkg::SEL_MODE    :
                         hit_restart ? loop_guard_pkg::SEL_RESTART :
                         hit_cause   ? loop_guard_pkg::SEL_CAUSE   :
                                       loop_guard_pkg::SEL_NONE;
    assign rd_cause    = addr_phase && !hwrite && hit_cause;
    assign wdata       = hwdata[7:0];

    // restart register reads its fixed pattern whatever was written
    assign rd_byte = hit_mode    ? mode_r :
                     hit_restart ? loop_guard_pkg::RESTART_READ :
                     hit_cause   ? {3'h0, cause_r, 4'h0} :
                                   8'h00;

    // =====================================================================
    // data phase write events
    // =====================================================================
    logic                             wr_mode;
    logic                             wr_restart;
    logic                             key_ok;
    logic                             first_mode_wr;
    logic                             viol_mode;
    logic                             viol_key;
    logic                             viol_bit;
    logic                             violation;
    logic                             restart_ok;

    assign wr_mode     = wr_pend_r && (wr_sel_r == loop_guard_pkg::SEL_MODE);
    assign wr_restart  = wr_pend_r &&
                         (wr_sel_r == loop_guard_pkg::SEL_RESTART);
    assign key_ok      = (wdata == loop_guard_pkg::RESTART_KEY);
    // bit-wise mode writes are not allowed: dropped before the first write or once stopped, a reset otherwise
    assign first_mode_wr = wr_mode && !wr_bit_r && !mode_written_r;
    assign viol_mode   = wr_mode && mode_written_r && !stopped_r;
    assign viol_key    = wr_restart && !wr_bit_r && !key_ok &&
                         !stopped_r;
    assign viol_bit    = wr_restart && wr_bit_r && !stopped_r;
    assign violation   = viol_mode || viol_key || viol_bit;
    assign restart_ok  = wr_restart && !wr_bit_r && key_ok;

    // =====================================================================
    // new mode value
    // =====================================================================
    logic [1:0]                       clk_field;
    logic [7:0]                       mode_nxt;

    // unstoppable option keeps the slow clock whatever is written
    assign clk_field = opt_r ? 2'b00 :
                       wdata[loop_guard_pkg::MODE_CLK_HI_POS:
                             loop_guard_pkg::MODE_CLK_LO_POS];
    // upper bits hold the fixed pattern
    assign mode_nxt  = {loop_guard_pkg::MODE_FIXED, clk_field,
                        wdata[loop_guard_pkg::MODE_OVF_MSB:0]};

    // =====================================================================
    // clock source and gating
    // =====================================================================
    loop_guard_pkg::src_t             src;
    logic                             sys_gate;
    logic                             slow_gate;
    logic                             tick;
    logic                             overflow;
    logic                             cnt_clear;
    logic [loop_guard_pkg::CNT_W-1:0] count;

    assign src = mode_r[loop_guard_pkg::MODE_CLK_HI_POS] ?
                     loop_guard_pkg::SRC_STOP :
                 mode_r[loop_guard_pkg::MODE_CLK_LO_POS] ?
                     loop_guard_pkg::SRC_SYS : loop_guard_pkg::SRC_SLOW;

    // fx source: stops with fx, in halt/stop and while settling
    assign sys_gate  = sys_tick && sys_clk_running && !halt_mode &&
                       !stop_mode && !osc_stabilizing;
    // slow source: unstoppable option never pauses
    assign slow_gate = slow_tick &&
                       (opt_r || (!halt_mode && !stop_mode &&
                        !(cpu_on_sys_clk && slow_osc_stopped)));

    // held count simply waits for the next gated step
    always_comb begin
        case (src)
            loop_guard_pkg::SRC_SLOW: tick = slow_gate;
            loop_guard_pkg::SRC_SYS:  tick = sys_gate;
            loop_guard_pkg::SRC_STOP: tick = 1'b0;
            default:                  tick = 1'b0;
        endcase
    end

    assign cnt_clear = first_mode_wr || viol_mode || restart_ok ||
                       int_rst_r;

    loop_guard_counter u_counter (
        .clk      (clk),
        .rst_n    (rst_n),
        .clear    (cnt_clear),
        .tick     (tick),
        .src_sys  (src == loop_guard_pkg::SRC_SYS),
        .ovf_sel  (mode_r[loop_guard_pkg::MODE_OVF_MSB:0]),
        .overflow (overflow),
        .count    (count)
    );

    logic                             fire;
    assign fire = (overflow || violation) && !int_rst_r;

    // =====================================================================
    // option strap, taken once after reset release
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_r       <= 1'b0;
            opt_taken_r <= 1'b0;
        end else if (!opt_taken_r) begin
            opt_r       <= option_unstoppable;
            opt_taken_r <= 1'b1;
        end
    end

    // =====================================================================
    // mode register and write-once tracking
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r         <= loop_guard_pkg::MODE_RESET;
            mode_written_r <= 1'b0;
            stopped_r      <= 1'b0;
        end else if (int_rst_r) begin
            mode_r         <= loop_guard_pkg::MODE_RESET;
            mode_written_r <= 1'b0;
            stopped_r      <= 1'b0;
        end else if (first_mode_wr) begin
            mode_r         <= mode_nxt;
            mode_written_r <= 1'b1;
            stopped_r      <= clk_field[1];
        end
    end

    // =====================================================================
    // internal reset pulse and cause flag
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_rst_r <= 1'b0;
        end else begin
            int_rst_r <= fire;
        end
    end

    // set wins over the read-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= loop_guard_pkg::CAUSE_RESET[
                           loop_guard_pkg::CAUSE_FLAG_POS];
        end else if (fire) begin
            cause_r <= 1'b1;
        end else if (rd_cause) begin
            cause_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counting_r <= 1'b0;
        end else begin
            counting_r <= (src != loop_guard_pkg::SRC_STOP) && !int_rst_r;
        end
    end

    // =====================================================================
    // bus slave: address phase capture
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_sel_r  <= loop_guard_pkg::SEL_NONE;
            wr_bit_r  <= 1'b0;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            wr_sel_r  <= sel_now;
            wr_bit_r  <= bit_manip;
        end
    end

    // =====================================================================
    // bus slave: read data and response
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata_r <= {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hready_r <= 1'b0;
            hresp_r  <= 1'b0;
        end else begin
            hready_r <= 1'b1;
            hresp_r  <= 1'b0;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign hreadyout                   = hready_r;
    assign hrdata                      = hrdata_r;
    assign hresp                       = hresp_r;
    assign internal_reset              = int_rst_r;
    assign loop_guard_reset_cause_flag = cause_r;
    assign counting                    = counting_r;

endmodule

// ### dv/loop_guard_properties.sv
`timescale 1ns/1ps
module loop_guard_properties (
    input wire logic        clk,                         // clock
    input wire logic        rst_n,                       // async reset
    input wire logic        hsel,                        // select
    input wire logic [31:0] haddr,                       // address
    input wire logic [1:0]  htrans,                      // transfer
    input wire logic        hwrite,                      // write
    input wire logic [31:0] hwdata,                      // write data
    input wire logic        hready,                      // bus ready
    input wire logic [31:0] hrdata,                      // read data
    input wire logic        bit_manip,                   // bit access
    input wire logic        option_unstoppable,          // strap
    input wire logic        internal_reset,              // reset pulse
    input wire logic        loop_guard_reset_cause_flag, // cause bit
    input wire logic        counting                     // advancing
);
    // ==========
    // write-once state as seen on the bus
    // ==========
    logic acc;
    logic wr_mode_d_r, written_r, stopped_r;
    assign acc = hsel & hready & htrans[1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_mode_d_r <= 1'b0;
            written_r   <= 1'b0;
            stopped_r   <= 1'b0;
        end else begin
            wr_mode_d_r <= acc & hwrite & ~bit_manip
                           & (haddr == loop_guard_pkg::MODE_ADDR);
            if (internal_reset) begin
                written_r <= 1'b0;
                stopped_r <= 1'b0;
            end else if (wr_mode_d_r & ~written_r) begin
                written_r <= 1'b1;
                stopped_r <= hwdata[4] & ~option_unstoppable;
            end
        end
    end
    // ==========
    // properties
    // ==========
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence restart_wr(bm);
        acc && hwrite && bit_manip == bm
            && haddr == loop_guard_pkg::RESTART_ADDR;
    endsequence
    sequence reg_rd(addr);
        acc && !hwrite && haddr == addr;
    endsequence
    a_bad_key_reset: assert property (restart_wr(1'b0) ##1
        (hwdata[7:0] != loop_guard_pkg::RESTART_KEY && !stopped_r)
        |=> ##[0:1] internal_reset) else $error("bad key without reset");
    a_bit_access_reset: assert property (restart_wr(1'b1) ##1
        !stopped_r |=> ##[0:1] internal_reset)
        else $error("bit access without reset");
    a_second_write_reset: assert property (
        wr_mode_d_r && written_r && !stopped_r |=> ##[0:1] internal_reset)
        else $error("second mode write without reset");
    a_stop_keeps_quiet: assert property (
        stopped_r |-> !internal_reset) else $error("reset while stopped");
    a_pulse_one_cycle: assert property (
        internal_reset |=> !internal_reset) else $error("pulse too long");
    a_cause_with_reset: assert property (
        internal_reset |-> loop_guard_reset_cause_flag)
        else $error("cause flag not set");
    a_restart_reads_fixed: assert property (
        reg_rd(loop_guard_pkg::RESTART_ADDR) |=>
        hrdata[7:0] == loop_guard_pkg::RESTART_READ)
        else $error("restart read value");
    a_mode_reset_value: assert property (
        reg_rd(loop_guard_pkg::MODE_ADDR) ##0 !written_r |=>
        hrdata[7:0] == loop_guard_pkg::MODE_RESET)
        else $error("mode reset value");
    a_stopped_idle: assert property (
        stopped_r && $past(stopped_r) |-> !counting)
        else $error("counting while stopped");
    a_never_stops: assert property (
        option_unstoppable && written_r |-> counting)
        else $error("stopped under strap");
endmodule

bind loop_guard loop_guard_properties i_loop_guard_properties (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .bit_manip, .option_unstoppable, .internal_reset,
    .loop_guard_reset_cause_flag, .counting
);

// ### dv/loop_guard_env.sv
`timescale 1ns/1ps
module loop_guard_env (
    input  wire logic       clk,            // system clock
    input  wire logic       rst_n,          // async reset
    input  wire logic       run_slow,       // slow oscillator stepping
    input  wire logic       run_sys,        // system clock stepping
    input  wire logic       internal_reset, // chip reset request
    output logic            slow_tick,      // slow count step
    output logic            sys_tick,       // system count step
    output logic [7:0]      pulses_r        // reset requests taken
);
    // ==========
    // clock steps and reset controller tally
    // ==========
    assign slow_tick = run_slow;
    assign sys_tick  = run_sys;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulses_r <= 8'h00;
        end else if (internal_reset) begin
            pulses_r <= pulses_r + 8'h01;
        end
    end
endmodule

// ### dv/loop_guard_bench.sv
`timescale 1ns/1ps
module loop_guard_bench;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        bit_manip = 1'b0, option_unstoppable = 1'b0;
    logic        run_slow = 1'b0, run_sys = 1'b0;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [5:0]  pause_v = 6'h00;
    logic        hreadyout, hresp, slow_tick, sys_tick, internal_reset;
    logic        cause_flag, counting;
    logic [7:0]  pulses, rd, exp_pulses = 8'h00;
    logic [5:0]  slow_pause [3] = '{6'h01, 6'h02, 6'h30};
    int          num_errors = 0, samples_checked = 0;

    always #12.5 clk = ~clk;

    loop_guard i_loop_guard (
        .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .bit_manip,
        .option_unstoppable, .slow_tick, .sys_tick,
        .sys_clk_running(~pause_v[3]), .halt_mode(pause_v[0]),
        .stop_mode(pause_v[1]), .osc_stabilizing(pause_v[2]),
        .slow_osc_stopped(pause_v[4]), .cpu_on_sys_clk(pause_v[5]),
        .internal_reset, .loop_guard_reset_cause_flag(cause_flag), .counting
    );
    loop_guard_env i_loop_guard_env (
        .clk, .rst_n, .run_slow, .run_sys, .internal_reset, .slow_tick,
        .sys_tick, .pulses_r(pulses)
    );

    // ==========
    // bus, tick and compare tasks
    // ==========
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [7:0] d, input logic bm);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= loop_guard_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        bit_manip <= bm;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        bit_manip <= 1'b0;
        hwdata <= {24'h000000, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata[7:0];
    endtask
    task automatic ticks(input int n, input logic s, input logic y);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            run_slow <= s;
            run_sys <= y;
        end
        @(posedge clk);
        run_slow <= 1'b0;
        run_sys <= 1'b0;
    endtask
    task automatic pulses_now(input logic [7:0] n);
        repeat (4) @(posedge clk);
        exp_pulses = exp_pulses + n;
        check("reset pulses", pulses, exp_pulses);
    endtask
    task automatic do_reset(input logic opt);
        @(posedge clk);
        rst_n <= 1'b0;
        option_unstoppable <= opt;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        exp_pulses = 8'h00;
        repeat (2) @(posedge clk);
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========
    // scenarios
    // ==========
    initial begin
        do_reset(1'b0);
        xfer(1'b0, loop_guard_pkg::MODE_ADDR, 8'h00, 1'b0);
        check("mode", rd, loop_guard_pkg::MODE_RESET);
        xfer(1'b0, loop_guard_pkg::RESTART_ADDR, 8'h00, 1'b0);
        check("restart", rd, loop_guard_pkg::RESTART_READ);
        xfer(1'b0, 32'h0000FF54, 8'h00, 1'b0);
        check("unmapped", rd, 8'h00);
        check("counting", {7'h00, counting}, 8'h01);
        check("hresp", {7'h00, hresp}, 8'h00);
        ticks(1000, 1'b1, 1'b0);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h60, 1'b0);
        ticks(2047, 1'b1, 1'b0);
        pulses_now(8'h00);
        xfer(1'b1, loop_guard_pkg::RESTART_ADDR, 8'hAC, 1'b0);
        xfer(1'b0, loop_guard_pkg::RESTART_ADDR, 8'h00, 1'b0);
        check("restart", rd, loop_guard_pkg::RESTART_READ);
        ticks(1000, 1'b1, 1'b0);
        foreach (slow_pause[k]) begin
            pause_v <= slow_pause[k];
            ticks(40, 1'b1, 1'b0);
        end
        pause_v <= 6'h00;
        ticks(1047, 1'b1, 1'b0);
        pulses_now(8'h00);
        ticks(1, 1'b1, 1'b0);
        pulses_now(8'h01);
        check("cause flag", {7'h00, cause_flag}, 8'h01);
        xfer(1'b0, loop_guard_pkg::CAUSE_ADDR, 8'h00, 1'b0);
        check("cause", rd, 8'h10);
        xfer(1'b0, loop_guard_pkg::CAUSE_ADDR, 8'h00, 1'b0);
        check("cause", rd, 8'h00);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h68, 1'b0);
        xfer(1'b0, loop_guard_pkg::MODE_ADDR, 8'h00, 1'b0);
        check("mode", rd, 8'h68);
        ticks(4096, 1'b1, 1'b1);
        for (int k = 0; k < 4; k++) begin
            pause_v <= 6'h01 << k;
            ticks(30, 1'b1, 1'b1);
        end
        pause_v <= 6'h00;
        ticks(4095, 1'b1, 1'b1);
        pulses_now(8'h00);
        ticks(1, 1'b1, 1'b1);
        pulses_now(8'h01);
        xfer(1'b1, loop_guard_pkg::RESTART_ADDR, 8'h55, 1'b0);
        pulses_now(8'h01);
        xfer(1'b1, loop_guard_pkg::RESTART_ADDR, 8'hAC, 1'b1);
        pulses_now(8'h01);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h60, 1'b0);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h60, 1'b0);
        pulses_now(8'h01);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h78, 1'b0);
        repeat (2) @(posedge clk);
        check("counting", {7'h00, counting}, 8'h00);
        xfer(1'b1, loop_guard_pkg::RESTART_ADDR, 8'h55, 1'b0);
        xfer(1'b1, loop_guard_pkg::RESTART_ADDR, 8'hAC, 1'b1);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h60, 1'b0);
        ticks(3000, 1'b1, 1'b1);
        pulses_now(8'h00);
        do_reset(1'b1);
        xfer(1'b1, loop_guard_pkg::MODE_ADDR, 8'h70, 1'b0);
        repeat (2) @(posedge clk);
        check("counting", {7'h00, counting}, 8'h01);
        xfer(1'b0, loop_guard_pkg::MODE_ADDR, 8'h00, 1'b0);
        check("mode", rd, 8'h60);
        pause_v <= 6'h03;
        ticks(2048, 1'b1, 1'b0);
        pause_v <= 6'h00;
        pulses_now(8'h01);
        xfer(1'b1, loop_guard_pkg::RESTART_ADDR, 8'h55, 1'b0);
        pulses_now(8'h01);
        report_and_stop;
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
endmodule
